// [src/pbo_pkg.sv]
// Purpose: Shared constants for the port B low nibble override block
// Assumes: Pin indices 3..0 of the port
// Notes: Override values that are fixed by design live here
package pbo_pkg;
  localparam int PBO_NPINS = 4;
  localparam int PBO_PIN_DATA = 0;
  localparam int PBO_PIN_DOUT = 1;
  localparam int PBO_PIN_CLK = 2;
  localparam int PBO_PIN_CMPB = 3;
  localparam logic PBO_PULLUP_VAL = 1'h0;
  localparam logic PBO_INPUT_EN_VAL = 1'h1;
  localparam logic [3:0] PBO_RST_NIBBLE = 4'h0;
endpackage : pbo_pkg

// [src/pbo_irq_gate.sv]
// Purpose: Interrupt enable qualification for the low pin-change group and start detect
// Assumes: All inputs are in the core clock domain
// Notes: Purely combinational
module pbo_irq_gate (
  input wire logic global_irq_flag,
  input wire logic pin_change_group_low_en,
  input wire logic start_cond_irq_en_bit,
  input wire logic alt_masks_pin_change,
  output logic pin_change_low_en,
  output logic start_detect_irq_en
);
  import pbo_pkg::*;

  // Group enable only while no alternate function masks it
  assign pin_change_low_en = global_irq_flag & pin_change_group_low_en
                             & ~alt_masks_pin_change;
  assign start_detect_irq_en = global_irq_flag & start_cond_irq_en_bit;
endmodule : pbo_irq_gate

// [src/pbo_override.sv]
// Purpose: Alternate-function override signals for port B pins 3..0
// Assumes: Mode, enable and port bits come from core-clock logic, so no synchronisers
// Assumes: The serial unit never selects two-wire and three-wire mode together
// Notes: Equations are combinational, each output then registered once
// Notes: Pin change group enable drops only when all four pins are masked
// Notes: Output registers are split by override kind
//
// What this block does
// - Two-wire mode takes pull-up and direction of clock and data pins, pull-up off
// - Clock pin direction is output if its dir bit and (hold or port bit low)
// - Data pin is open drain, low when dir set and (shift data low or port bit low)
// - Pin 3 drives compare B when enabled; input override only with pin change, no B
// - Pin 2 value overridden in two-wire output or compare B; value zero in two-wire output, else B
// - Pin 1 value overridden in three-wire or compare A; data out or gated A
// - Pin 0 value override enabled in two-wire output or compare A enabled
// - Pin 0 value zero in two-wire output, else compare A and its enable
// - Low pin-change interrupt needs global flag, group enable and not all four pins masked
// - Start interrupt needs global flag and its enable; keeps inputs on pins 2 and 0
// - Serial data out reaches pin 1 only in three-wire mode
module pbo_override (
  input wire logic clk,
  input wire logic srst,
  input wire logic serial_two_wire_mode,
  input wire logic serial_three_wire_mode,
  input wire logic serial_clock_hold_req,
  input wire logic serial_shift_out_msb,
  input wire logic serial_data_out,
  input wire logic start_cond_irq_en_bit,
  input wire logic global_irq_flag,
  input wire logic pin_change_group_low_en,
  input wire logic timer_cmp_a_out_en,
  input wire logic timer_cmp_b_out_en,
  input wire logic timer_cmp_a_signal,
  input wire logic timer_cmp_b_signal,
  input wire logic [pbo_pkg::PBO_NPINS-1:0] port_dir_bits,
  input wire logic [pbo_pkg::PBO_NPINS-1:0] port_out_bits,
  output logic [pbo_pkg::PBO_NPINS-1:0] pullup_override_en,
  output logic [pbo_pkg::PBO_NPINS-1:0] pullup_override_val,
  output logic [pbo_pkg::PBO_NPINS-1:0] direction_override_en,
  output logic [pbo_pkg::PBO_NPINS-1:0] direction_override_val,
  output logic [pbo_pkg::PBO_NPINS-1:0] pin_value_override_en,
  output logic [pbo_pkg::PBO_NPINS-1:0] pin_value_override_val,
  output logic [pbo_pkg::PBO_NPINS-1:0] input_enable_override_en,
  output logic [pbo_pkg::PBO_NPINS-1:0] input_enable_override_val,
  output logic pin_change_low_irq_en,
  output logic start_detect_irq_en
);
  import pbo_pkg::*;

  logic port_dir_bit_zero;
  logic port_dir_bit_two;
  logic port_out_bit_zero;
  logic port_out_bit_two;
  logic tw_clk_out;
  logic tw_data_out;
  logic pc_en_raw;
  logic start_en_raw;
  logic [PBO_NPINS-1:0] pullup_override_en_d, pullup_override_val_d, direction_override_en_d, direction_override_val_d, pin_value_override_en_d, pin_value_override_val_d, input_enable_override_en_d, input_enable_override_val_d;
  logic [PBO_NPINS-1:0] pullup_override_en_q, pullup_override_val_q, direction_override_en_q, direction_override_val_q, pin_value_override_en_q, pin_value_override_val_q, input_enable_override_en_q, input_enable_override_val_q;
  logic pc_en_q;
  logic start_en_q;
  logic serial_active;
  logic cmp_a_gated;
  logic [PBO_NPINS-1:0] pc_mask;
  logic [PBO_NPINS-1:0] pc_open;
  logic [PBO_NPINS-1:0] start_keep;
  logic pc_all_masked;
  logic pc_gate_en;

  // Pins owned by the two-wire mode and watched by the start detector
  function automatic logic two_wire_pin(input int pin);
    return (pin == PBO_PIN_CLK) || (pin == PBO_PIN_DATA);
  endfunction : two_wire_pin

  assign port_dir_bit_zero = port_dir_bits[PBO_PIN_DATA];
  assign port_dir_bit_two = port_dir_bits[PBO_PIN_CLK];
  assign port_out_bit_zero = port_out_bits[PBO_PIN_DATA];
  assign port_out_bit_two = port_out_bits[PBO_PIN_CLK];
  assign tw_clk_out = serial_two_wire_mode & port_dir_bit_two;
  assign tw_data_out = serial_two_wire_mode & port_dir_bit_zero;
  assign serial_active = serial_two_wire_mode | serial_three_wire_mode;
  assign cmp_a_gated = timer_cmp_a_out_en & timer_cmp_a_signal;

  // Group enable before masking; masking is applied by the gate
  assign pc_en_raw = global_irq_flag & pin_change_group_low_en;

  // Alternate functions that mask pin change, one bit a pin
  always_comb begin
    pc_mask = PBO_RST_NIBBLE;
    pc_mask[PBO_PIN_CMPB] = timer_cmp_b_out_en;
    pc_mask[PBO_PIN_CLK] = serial_active | timer_cmp_b_out_en;
    pc_mask[PBO_PIN_DOUT] = serial_three_wire_mode | timer_cmp_a_out_en;
    pc_mask[PBO_PIN_DATA] = serial_active | timer_cmp_a_out_en;
  end

  // Per-pin pin-change enable and start-detect input keep
  for (genvar gi = 0; gi < PBO_NPINS; gi++) begin : g_pin
    assign pc_open[gi] = pc_en_raw & ~pc_mask[gi];
    assign start_keep[gi] = start_en_raw & two_wire_pin(gi);
  end

  // Group masked only when every pin is taken by an alternate function
  assign pc_all_masked = &pc_mask;

  pbo_irq_gate u_irq_gate (
    .global_irq_flag(global_irq_flag),
    .pin_change_group_low_en(pin_change_group_low_en),
    .start_cond_irq_en_bit(start_cond_irq_en_bit),
    .alt_masks_pin_change(pc_all_masked),
    .pin_change_low_en(pc_gate_en),
    .start_detect_irq_en(start_en_raw)
  );

  always_comb begin
    // Pull-up: only forced off, never on
    pullup_override_en_d = PBO_RST_NIBBLE;
    pullup_override_val_d = {PBO_NPINS{PBO_PULLUP_VAL}};
    pullup_override_en_d[PBO_PIN_CLK] = serial_two_wire_mode;
    pullup_override_en_d[PBO_PIN_DATA] = serial_two_wire_mode;
    direction_override_en_d = PBO_RST_NIBBLE;
    direction_override_val_d = PBO_RST_NIBBLE;
    direction_override_en_d[PBO_PIN_CLK] = serial_two_wire_mode;
    direction_override_en_d[PBO_PIN_DATA] = serial_two_wire_mode;
    direction_override_val_d[PBO_PIN_CLK] = (serial_clock_hold_req | ~port_out_bit_two) & port_dir_bit_two;
    // Open drain: output only to pull low
    direction_override_val_d[PBO_PIN_DATA] = (~serial_shift_out_msb | ~port_out_bit_zero)
                           & port_dir_bit_zero;
    // Pin value: timer compare and serial data outputs
    pin_value_override_en_d = PBO_RST_NIBBLE;
    pin_value_override_val_d = PBO_RST_NIBBLE;
    pin_value_override_en_d[PBO_PIN_CMPB] = timer_cmp_b_out_en;
    pin_value_override_val_d[PBO_PIN_CMPB] = timer_cmp_b_signal;
    pin_value_override_en_d[PBO_PIN_CLK] = tw_clk_out | timer_cmp_b_out_en;
    pin_value_override_val_d[PBO_PIN_CLK] = ~tw_clk_out & timer_cmp_b_signal;
    pin_value_override_en_d[PBO_PIN_DOUT] = serial_three_wire_mode | timer_cmp_a_out_en;
    pin_value_override_val_d[PBO_PIN_DOUT] = serial_three_wire_mode ? serial_data_out
                           : cmp_a_gated;
    pin_value_override_en_d[PBO_PIN_DATA] = tw_data_out | timer_cmp_a_out_en;
    pin_value_override_val_d[PBO_PIN_DATA] = ~tw_data_out & cmp_a_gated;
    // Input enable: kept on for unmasked pin change and start detect
    input_enable_override_en_d = PBO_RST_NIBBLE;
    input_enable_override_en_d[PBO_PIN_CMPB] = pc_open[PBO_PIN_CMPB];
    input_enable_override_en_d[PBO_PIN_CLK] = pc_open[PBO_PIN_CLK]
                           | start_keep[PBO_PIN_CLK];
    input_enable_override_en_d[PBO_PIN_DOUT] = pc_open[PBO_PIN_DOUT];
    input_enable_override_en_d[PBO_PIN_DATA] = pc_open[PBO_PIN_DATA]
                            | start_keep[PBO_PIN_DATA];
    input_enable_override_val_d = {PBO_NPINS{PBO_INPUT_EN_VAL}};
  end

  // Pull-up overrides
  always_ff @(posedge clk) begin
    if (srst) begin
      pullup_override_en_q <= PBO_RST_NIBBLE;
      pullup_override_val_q <= PBO_RST_NIBBLE;
    end else begin
      pullup_override_en_q <= pullup_override_en_d;
      pullup_override_val_q <= pullup_override_val_d;
    end
  end

  // Direction overrides
  always_ff @(posedge clk) begin
    if (srst) begin
      direction_override_en_q <= PBO_RST_NIBBLE;
      direction_override_val_q <= PBO_RST_NIBBLE;
    end else begin
      direction_override_en_q <= direction_override_en_d;
      direction_override_val_q <= direction_override_val_d;
    end
  end

  // Pin value overrides
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_value_override_en_q <= PBO_RST_NIBBLE;
      pin_value_override_val_q <= PBO_RST_NIBBLE;
    end else begin
      pin_value_override_en_q <= pin_value_override_en_d;
      pin_value_override_val_q <= pin_value_override_val_d;
    end
  end

  // Input enable overrides
  always_ff @(posedge clk) begin
    if (srst) begin
      input_enable_override_en_q <= PBO_RST_NIBBLE;
      input_enable_override_val_q <= PBO_RST_NIBBLE;
    end else begin
      input_enable_override_en_q <= input_enable_override_en_d;
      input_enable_override_val_q <= input_enable_override_val_d;
    end
  end

  // Pin change group enable, cleared when every pin is taken by an alternate function
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_en_q <= 1'h0;
    end else begin
      pc_en_q <= pc_gate_en;
    end
  end

  // Start detect enable
  always_ff @(posedge clk) begin
    if (srst) begin
      start_en_q <= 1'h0;
    end else begin
      start_en_q <= start_en_raw;
    end
  end

  // Every output straight from its flop

  assign pullup_override_en = pullup_override_en_q;
  assign pullup_override_val = pullup_override_val_q;
  assign direction_override_en = direction_override_en_q;
  assign direction_override_val = direction_override_val_q;
  assign pin_value_override_en = pin_value_override_en_q;
  assign pin_value_override_val = pin_value_override_val_q;
  assign input_enable_override_en = input_enable_override_en_q;
  assign input_enable_override_val = input_enable_override_val_q;
  assign pin_change_low_irq_en = pc_en_q;
  assign start_detect_irq_en = start_en_q;
endmodule : pbo_override

// [sim/pbo_override_chk.sv]
// Purpose: Port-level checks for the low nibble override block
// Assumes: Bound into pbo_override, one clock domain
// Notes: Outputs follow the inputs of the previous edge
module pbo_override_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic serial_two_wire_mode,
  input wire logic serial_three_wire_mode,
  input wire logic serial_clock_hold_req,
  input wire logic serial_shift_out_msb,
  input wire logic global_irq_flag,
  input wire logic pin_change_group_low_en,
  input wire logic start_cond_irq_en_bit,
  input wire logic timer_cmp_a_out_en,
  input wire logic timer_cmp_b_out_en,
  input wire logic timer_cmp_b_signal,
  input wire logic pin_change_low_irq_en,
  input wire logic start_detect_irq_en,
  input wire logic [3:0] port_dir_bits,
  input wire logic [3:0] port_out_bits,
  input wire logic [3:0] pullup_override_en,
  input wire logic [3:0] pullup_override_val,
  input wire logic [3:0] direction_override_en,
  input wire logic [3:0] direction_override_val,
  input wire logic [3:0] pin_value_override_en,
  input wire logic [3:0] pin_value_override_val,
  input wire logic [3:0] input_enable_override_en,
  input wire logic [3:0] input_enable_override_val
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  two_wire_a: assert property (serial_two_wire_mode |=> pullup_override_en == 4'h5 &&
    direction_override_en == 4'h5) else $error("two-wire take-over wrong");
  no_two_wire_a: assert property (!serial_two_wire_mode |=> pullup_override_en == 4'h0 &&
    direction_override_en == 4'h0) else $error("take-over outside two-wire mode");
  fixed_vals_a: assert property (1'h1 |=> pullup_override_val == 4'h0 &&
    input_enable_override_val == 4'hF) else $error("fixed override values wrong");
  clk_dir_a: assert property (1'h1 |=> direction_override_val[2] ==
    $past((serial_clock_hold_req | ~port_out_bits[2]) & port_dir_bits[2]))
    else $error("clock pin direction wrong");
  data_dir_a: assert property (1'h1 |=> direction_override_val[0] ==
    $past((~serial_shift_out_msb | ~port_out_bits[0]) & port_dir_bits[0]))
    else $error("data pin open drain wrong");
  cmp_b_pin_a: assert property (timer_cmp_b_out_en |=> pin_value_override_en[3] &&
    pin_value_override_val[3] == $past(timer_cmp_b_signal) && !input_enable_override_en[3])
    else $error("compare B pin wrong");
  start_en_a: assert property (global_irq_flag && start_cond_irq_en_bit |=>
    start_detect_irq_en && input_enable_override_en[2] && input_enable_override_en[0])
    else $error("start interrupt enable wrong");
  pc_irq_a: assert property ($rose(pin_change_low_irq_en) |->
    $past(global_irq_flag && pin_change_group_low_en)) else $error("pin change enable wrong");
  pc_mask_a: assert property (1'h1 |=> pin_change_low_irq_en ==
    $past(global_irq_flag && pin_change_group_low_en && !(timer_cmp_b_out_en
    && (timer_cmp_a_out_en || serial_three_wire_mode))))
    else $error("pin change group masking wrong");
  cover property (serial_two_wire_mode && port_dir_bits[2] ##1 pin_value_override_en[2]);
  cover property (global_irq_flag && timer_cmp_a_out_en && timer_cmp_b_out_en);
  cover property (start_detect_irq_en);
  cover property (pin_change_low_irq_en);
endmodule : pbo_override_chk
bind pbo_override pbo_override_chk chk_u (.*);

// [sim/pbo_peer.sv]
// Purpose: Serial unit and timer levels seen by the override block
// Assumes: rnd changes only at falling clock edges
// Notes: The serial unit selects at most one mode at a time
module pbo_peer (
  input wire logic [8:0] rnd,
  output logic serial_two_wire_mode,
  output logic serial_three_wire_mode,
  output logic serial_clock_hold_req,
  output logic serial_shift_out_msb,
  output logic serial_data_out,
  output logic timer_cmp_a_out_en,
  output logic timer_cmp_b_out_en,
  output logic timer_cmp_a_signal,
  output logic timer_cmp_b_signal
);
  timeunit 1ns;
  timeprecision 1ns;
  assign serial_two_wire_mode = rnd[0];
  assign serial_three_wire_mode = ~rnd[0] & rnd[1];
  assign {serial_clock_hold_req, serial_shift_out_msb, serial_data_out, timer_cmp_a_out_en,
    timer_cmp_b_out_en, timer_cmp_a_signal, timer_cmp_b_signal} = rnd[8:2];
endmodule : pbo_peer

// [sim/tb_port_b_low_nibble_override.sv]
// Purpose: Random scoreboard bench for the low nibble override block
// Assumes: One cycle from inputs to outputs
// Notes: Third test pulses reset in mid-run
module tb_port_b_low_nibble_override;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, srst = 1'h1, start_cond_irq_en_bit = 1'h0, global_irq_flag = 1'h0;
  logic pin_change_group_low_en = 1'h0, pin_change_low_irq_en, start_detect_irq_en;
  logic serial_two_wire_mode, serial_three_wire_mode, serial_clock_hold_req;
  logic serial_shift_out_msb, serial_data_out, timer_cmp_a_out_en, timer_cmp_b_out_en;
  logic timer_cmp_a_signal, timer_cmp_b_signal;
  logic [3:0] port_dir_bits = 4'h0, port_out_bits = 4'h0, pullup_override_en;
  logic [3:0] pullup_override_val, direction_override_en, direction_override_val;
  logic [3:0] pin_value_override_en, pin_value_override_val;
  logic [3:0] input_enable_override_en, input_enable_override_val;
  logic [8:0] rnd = 9'h0;
  logic [31:0] r;
  logic [13:0] e, q[$];
  int seed = 96142, num_errors = 0, n_compared = 0, cyc = 0;
  wire tw = serial_two_wire_mode, th = serial_three_wire_mode, ae = timer_cmp_a_out_en;
  wire be = timer_cmp_b_out_en, a = timer_cmp_a_signal, b = timer_cmp_b_signal;
  wire pc = global_irq_flag & pin_change_group_low_en;
  wire si = global_irq_flag & start_cond_irq_en_bit;
  wire [3:0] d = port_dir_bits;
  always #25 clk = ~clk;
  pbo_override dut_u (.*);
  pbo_peer peer_u (.*);
  task automatic check(string nm, logic [3:0] s, logic [3:0] x);
    n_compared++;
    if (s !== x) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    for (int i = 0; i < 900; i++) begin
      @(negedge clk);
      r = $random(seed);
      rnd = r[8:0];
      {port_dir_bits, port_out_bits, global_irq_flag, pin_change_group_low_en} = r[18:9];
      start_cond_irq_en_bit = r[19];
      srst = i < 5 || (i >= 600 && r[23:20] == 4'h0);
      #1 q.push_back(srst ? 14'h0 : {pc & ~(be & (ae | th)), si,
        be, tw & d[2] | be, th | ae, tw & d[0] | ae,
        b, ~(tw & d[2]) & b, th ? serial_data_out : ae & a, ~(tw & d[0]) & ae & a,
        pc & ~be, ~(tw | th | be) & pc | si, ~(th | ae) & pc, ~(tw | th | ae) & pc | si});
      if (i % 300 == 299) $display("test %0d done", i / 300);
    end
    @(negedge clk);
    conclude();
  end
  always @(posedge clk) begin
    #1;
    if (q.size() > 0) begin
      e = q.pop_front();
      check("value_en", pin_value_override_en, e[11:8]);
      check("value", pin_value_override_val, e[7:4]);
      check("input_en", input_enable_override_en, e[3:0]);
      check("irq_en", {2'h0, pin_change_low_irq_en, start_detect_irq_en},
        {2'h0, e[13:12]});
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      conclude();
    end
  end
endmodule : tb_port_b_low_nibble_override
